// file: cace_map.svh
// Constants of the call, add, and and compare-jump execution block
`ifndef CACE_MAP_SVH
`define CACE_MAP_SVH
// Reset values
`define CACE_RST_PC 16'h0000
`define CACE_RST_STACK 8'h07
`define CACE_RST_ACC 8'h00
// Opcode fields
`define CACE_OP_CALL_LO 5'h11
`define CACE_OP_JUMP_LO 5'h01
`define CACE_HI_ADD 4'h2
`define CACE_HI_ADDWC 4'h3
`define CACE_HI_AND 4'h5
`define CACE_HI_CMPJ 4'hB
`define CACE_OP_AND_C 8'h82
`define CACE_OP_AND_CN 8'hB0
// Bit address to byte address
`define CACE_BIT_RAM_BASE 8'h20
`define CACE_BIT_SFR_LIMIT 8'h80
`endif

// file: cace_pkg.sv
// Types of the call, add, and and compare-jump execution block
package cace_pkg;
    // Sequencer states, Gray coded along fetch, operand and execute
    typedef enum logic [3:0] {
        S_FETCH = 4'h0, S_OPC = 4'h1, S_B2 = 4'h3, S_B3 = 4'h2,
        S_ADDR = 4'h6, S_PTR = 4'h7, S_OPND = 4'h5, S_EXEC = 4'h4,
        S_PUSH = 4'hC
    } cace_state_e;
    // Instruction kinds handled here
    typedef enum logic [3:0] {
        K_NONE, K_CALL, K_JUMP, K_ADD, K_ADDWC, K_AND_A, K_AND_DA,
        K_AND_DI, K_AND_C, K_AND_CN, K_CMPJ
    } cace_kind_e;
    // Source operand modes
    typedef enum logic [2:0] {
        M_NONE, M_REG, M_DIR, M_IND, M_IMM, M_BIT
    } cace_mode_e;
    typedef struct packed {
        cace_kind_e kind;
        cace_mode_e mode;
        logic [1:0] len;
    } cace_dec_s;
    typedef struct packed {
        logic carry;
        logic aux_carry_flag;
        logic signed_range_flag;
    } cace_flags_s;
    typedef struct packed {
        logic [15:0] addr;
        logic rd;
    } cace_prog_req_s;
    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
        logic indirect;
        logic rmw;
    } cace_data_req_s;
    typedef struct packed {
        cace_state_e state;
        logic [15:0] pc;
        logic [7:0] stack_pointer_reg;
        logic [7:0] acc;
        cace_flags_s flags;
        logic [7:0] opc;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] opnd;
        cace_prog_req_s prog_req;
        cace_data_req_s data_req;
        logic retire;
        logic bad_op;
    } cace_regs_s;
endpackage : cace_pkg

// file: cace_core.sv
// Execution core for absolute call/jump, add, logical and, compare-jump
`timescale 1ns/1ps
`include "cace_map.svh"

module cace_core (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [1:0] reg_bank,
    output cace_pkg::cace_prog_req_s prog_req,
    input wire logic [7:0] prog_data,
    output cace_pkg::cace_data_req_s data_req,
    input wire logic [7:0] data_rdata,
    output logic [15:0] pc,
    output logic [7:0] stack_pointer_reg,
    output logic [7:0] acc,
    output cace_pkg::cace_flags_s flags,
    output logic retire,
    output logic bad_op
);
    import cace_pkg::*;

    // ============================================================
    // Decode
    // ============================================================
    // Opcode to kind, source mode and length
    function automatic cace_dec_s decode(input logic [7:0] op);
        cace_dec_s d;
        d = '{kind: K_NONE, mode: M_NONE, len: 2'd1};
        if (op[4:0] == `CACE_OP_CALL_LO) begin
            d = '{kind: K_CALL, mode: M_NONE, len: 2'd2};
        end else if (op[4:0] == `CACE_OP_JUMP_LO) begin
            d = '{kind: K_JUMP, mode: M_NONE, len: 2'd2};
        end else if (op == `CACE_OP_AND_C) begin
            d = '{kind: K_AND_C, mode: M_BIT, len: 2'd2};
        end else if (op == `CACE_OP_AND_CN) begin
            d = '{kind: K_AND_CN, mode: M_BIT, len: 2'd2};
        end else if (op[7:4] == `CACE_HI_CMPJ && op[3:2] != 2'b00) begin
            d.kind = K_CMPJ;
            d.len = 2'd3;
            if (op[3]) begin
                d.mode = M_REG;
            end else if (op[1]) begin
                d.mode = M_IND;
            end else begin
                d.mode = op[0] ? M_DIR : M_IMM;
            end
        end else if (op[7:4] == `CACE_HI_ADD || op[7:4] == `CACE_HI_ADDWC
                     || op[7:4] == `CACE_HI_AND) begin
            if (op[7:4] == `CACE_HI_ADD) begin
                d.kind = K_ADD;
            end else if (op[7:4] == `CACE_HI_ADDWC) begin
                d.kind = K_ADDWC;
            end else begin
                d.kind = K_AND_A;
            end
            // Source mode from low nibble
            if (op[3]) begin
                d.mode = M_REG;
            end else if (op[3:1] == 3'b011) begin
                d.mode = M_IND;
            end else if (op[3:0] == 4'h5) begin
                d = '{kind: d.kind, mode: M_DIR, len: 2'd2};
            end else if (op[3:0] == 4'h4) begin
                d = '{kind: d.kind, mode: M_IMM, len: 2'd2};
            end else if (d.kind == K_AND_A && op[3:0] == 4'h2) begin
                d = '{kind: K_AND_DA, mode: M_DIR, len: 2'd2};
            end else if (d.kind == K_AND_A && op[3:0] == 4'h3) begin
                d = '{kind: K_AND_DI, mode: M_DIR, len: 2'd3};
            end else begin
                d = '{kind: K_NONE, mode: M_NONE, len: 2'd1};
            end
        end
        return d;
    endfunction : decode

    // Bit address to the byte that holds it
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        logic [7:0] a;
        a = {b[7:3], 3'b000};
        if (b < `CACE_BIT_SFR_LIMIT) begin
            a = `CACE_BIT_RAM_BASE + {4'h0, b[6:3]};
        end
        return a;
    endfunction : bit_byte

    cace_regs_s r;
    cace_regs_s n;
    cace_dec_s dec;
    logic [7:0] src;
    logic [7:0] first;
    logic [7:0] second;
    logic cin;
    logic bit_val;
    logic [8:0] sum9;
    logic [4:0] lo5;
    logic [7:0] lo8;
    logic [15:0] call_target;

    // ============================================================
    // Datapath
    // ============================================================
    // Operand selection and the adder with its carries
    always_comb begin
        dec = decode(r.opc);
        src = (dec.mode == M_IMM) ? r.b2 : r.opnd;
        cin = (dec.kind == K_ADDWC) & r.flags.carry;
        sum9 = {1'b0, r.acc} + {1'b0, src} + {8'h00, cin};
        lo5 = {1'b0, r.acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
        lo8 = {1'b0, r.acc[6:0]} + {1'b0, src[6:0]} + {7'h00, cin};
        // Accumulator forms compare against direct or immediate
        first = (dec.mode == M_DIR || dec.mode == M_IMM) ? r.acc : r.opnd;
        second = (dec.mode == M_DIR) ? r.opnd : r.b2;
        bit_val = r.opnd[r.b2[2:0]];
        call_target = {r.pc[15:11], r.opc[7:5], r.b2};
    end

    // ============================================================
    // Sequencer
    // ============================================================
    // Next state of every register
    always_comb begin
        n = r;
        n.prog_req.rd = 1'b0;
        n.data_req.rd = 1'b0;
        n.data_req.wr = 1'b0;
        n.data_req.rmw = 1'b0;
        n.retire = 1'b0;
        n.bad_op = 1'b0;
        case (r.state)
            S_FETCH: begin
                n.prog_req = '{addr: r.pc, rd: 1'b1};
                n.state = S_OPC;
            end
            S_OPC: begin
                n.opc = prog_data;
                if (decode(prog_data).len != 2'd1) begin
                    n.prog_req = '{addr: r.pc + 16'h0001, rd: 1'b1};
                    n.state = S_B2;
                end else begin
                    n.state = S_ADDR;
                end
            end
            S_B2: begin
                n.b2 = prog_data;
                if (dec.len == 2'd3) begin
                    n.prog_req = '{addr: r.pc + 16'h0002, rd: 1'b1};
                    n.state = S_B3;
                end else begin
                    n.state = S_ADDR;
                end
            end
            S_B3: begin
                n.b3 = prog_data;
                n.state = S_ADDR;
            end
            S_ADDR: begin
                // Advance past the instruction, wrapping
                n.pc = r.pc + {14'h0000, dec.len};
                n.data_req.indirect = 1'b0;
                n.data_req.rd = 1'b1;
                n.state = S_OPND;
                case (dec.mode)
                    M_REG: n.data_req.addr = {3'b000, reg_bank, r.opc[2:0]};
                    M_DIR: begin
                        n.data_req.addr = r.b2;
                        // Direct destinations read the port latch
                        n.data_req.rmw = (dec.kind == K_AND_DA)
                                         || (dec.kind == K_AND_DI);
                    end
                    M_BIT: n.data_req.addr = bit_byte(r.b2);
                    M_IND: begin
                        n.data_req.addr = {3'b000, reg_bank, 2'b00, r.opc[0]};
                        n.state = S_PTR;
                    end
                    default: begin
                        n.data_req.rd = 1'b0;
                        n.state = S_EXEC;
                    end
                endcase
                if (dec.kind == K_NONE) begin
                    n.bad_op = 1'b1;
                    n.state = S_FETCH;
                end
            end
            S_PTR: begin
                n.data_req.addr = data_rdata;
                n.data_req.indirect = 1'b1;
                n.data_req.rd = 1'b1;
                n.state = S_OPND;
            end
            S_OPND: begin
                n.opnd = data_rdata;
                n.state = S_EXEC;
            end
            S_EXEC: begin
                n.retire = 1'b1;
                n.state = S_FETCH;
                case (dec.kind)
                    K_CALL: begin
                        // Push return low byte
                        n.stack_pointer_reg = r.stack_pointer_reg + 8'h01;
                        n.data_req.addr = r.stack_pointer_reg + 8'h01;
                        n.data_req.wdata = r.pc[7:0];
                        n.data_req.indirect = 1'b1;
                        n.data_req.wr = 1'b1;
                        n.retire = 1'b0;
                        n.state = S_PUSH;
                    end
                    K_JUMP: n.pc = call_target;
                    K_ADD, K_ADDWC: begin
                        n.acc = sum9[7:0];
                        n.flags.carry = sum9[8];
                        n.flags.aux_carry_flag = lo5[4];
                        n.flags.signed_range_flag = sum9[8] ^ lo8[7];
                    end
                    K_AND_A: n.acc = r.acc & src;
                    K_AND_DA, K_AND_DI: begin
                        n.data_req.wdata = r.opnd & ((dec.kind == K_AND_DA)
                                                     ? r.acc : r.b3);
                        n.data_req.wr = 1'b1;
                    end
                    K_AND_C: n.flags.carry = r.flags.carry & bit_val;
                    K_AND_CN: n.flags.carry = r.flags.carry & ~bit_val;
                    K_CMPJ: begin
                        n.flags.carry = first < second;
                        if (first != second) begin
                            n.pc = r.pc + {{8{r.b3[7]}}, r.b3};
                        end
                    end
                    default: n.retire = 1'b1;
                endcase
            end
            S_PUSH: begin
                // Push return high byte and jump
                n.stack_pointer_reg = r.stack_pointer_reg + 8'h01;
                n.data_req.addr = r.stack_pointer_reg + 8'h01;
                n.data_req.wdata = r.pc[15:8];
                n.data_req.indirect = 1'b1;
                n.data_req.wr = 1'b1;
                n.pc = call_target;
                n.retire = 1'b1;
                n.state = S_FETCH;
            end
            default: n.state = S_FETCH;
        endcase
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
            r.state <= S_FETCH;
            r.pc <= `CACE_RST_PC;
            r.stack_pointer_reg <= `CACE_RST_STACK;
            r.acc <= `CACE_RST_ACC;
        end else if (ce) begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign prog_req = r.prog_req;
    assign data_req = r.data_req;
    assign pc = r.pc;
    assign stack_pointer_reg = r.stack_pointer_reg;
    assign acc = r.acc;
    assign flags = r.flags;
    assign retire = r.retire;
    assign bad_op = r.bad_op;

    // ============================================================
    // Checks
    // ============================================================
    logic exec_ce;
    assign exec_ce = ce && r.state == S_EXEC;

    call_push_lo_a: assert property (@(posedge clk) disable iff (!resetn)
        exec_ce && dec.kind == K_CALL |=> r.data_req.wr
        && r.data_req.addr == $past(r.stack_pointer_reg) + 8'h01
        && r.data_req.wdata == $past(r.pc[7:0]))
        else $error("call low byte push wrong");

    call_target_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && r.state == S_PUSH |=> r.pc[10:0] == {$past(r.opc[7:5]), $past(r.b2)}
        && r.pc[15:11] == $past(r.pc[15:11]) && r.data_req.wdata == $past(r.pc[15:8]))
        else $error("call target or high push wrong");

    jump_page_a: assert property (@(posedge clk) disable iff (!resetn)
        exec_ce && dec.kind == K_JUMP |=> r.pc[15:11] == $past(r.pc[15:11])
        && r.pc[10:8] == $past(r.opc[7:5]) && r.pc[7:0] == $past(r.b2) && retire)
        else $error("jump left page");

    add_carry_a: assert property (@(posedge clk) disable iff (!resetn)
        exec_ce && dec.kind == K_ADD |=> flags.carry
        == ((9'({1'b0, $past(r.acc)}) + 9'({1'b0, $past(src)})) > 9'h0FF))
        else $error("add carry wrong");

    signed_range_a: assert property (@(posedge clk) disable iff (!resetn)
        exec_ce && dec.kind == K_ADD |=> flags.signed_range_flag
        == ($past(r.acc[7]) == $past(src[7]) && acc[7] != $past(r.acc[7])))
        else $error("signed range flag wrong");

    and_flags_a: assert property (@(posedge clk) disable iff (!resetn)
        exec_ce && dec.kind == K_AND_A |=> $stable(flags)
        && acc == ($past(r.acc) & $past(src)))
        else $error("and changed flags or result");

    and_rmw_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && r.state == S_ADDR && (dec.kind == K_AND_DI || dec.kind == K_AND_DA)
        |=> data_req.rmw && data_req.rd && ce ##1 ce ##1 data_req.wr
        && data_req.addr == $past(data_req.addr, 2))
        else $error("direct and not from latch");

    bit_and_a: assert property (@(posedge clk) disable iff (!resetn)
        exec_ce && dec.kind == K_AND_CN |=> flags.carry
        == ($past(r.flags.carry) && !$past(bit_val)) && !data_req.wr)
        else $error("inverted bit and wrong");

    cmp_carry_a: assert property (@(posedge clk) disable iff (!resetn)
        exec_ce && dec.kind == K_CMPJ |=> flags.carry == ($past(first) < $past(second))
        && !data_req.wr)
        else $error("compare carry wrong");

    cmp_branch_a: assert property (@(posedge clk) disable iff (!resetn)
        exec_ce && dec.kind == K_CMPJ && first == second |=> $stable(pc))
        else $error("compare branched when equal");

    call_seen_c: cover property (@(posedge clk) disable iff (!resetn)
        ce && r.state == S_PUSH);
    cmp_taken_c: cover property (@(posedge clk) disable iff (!resetn)
        exec_ce && dec.kind == K_CMPJ && first != second);
    and_direct_c: cover property (@(posedge clk) disable iff (!resetn)
        exec_ce && dec.kind == K_AND_DI);
endmodule : cace_core

// file: cace_mem_model.sv
// Program memory and internal data memory that face the execution core
`timescale 1ns/1ps
module cace_mem_model (
    input wire logic clk,
    input wire cace_pkg::cace_prog_req_s prog_req,
    output logic [7:0] prog_data,
    input wire cace_pkg::cace_data_req_s data_req,
    output logic [7:0] data_rdata,
    input wire logic [7:0] port_pins
);
    import cace_pkg::*;
    // ==================================================
    // Storage
    logic [7:0] pmem [0:65535];
    logic [7:0] iram [0:255];
    logic [7:0] sfr [0:127];
    logic [7:0] prog_last = 8'h00;
    logic [7:0] data_last = 8'h00;
    localparam logic [7:0] PORT_ADDR = 8'h90;
    // ==================================================
    // Read paths, answering in the cycle of the strobe
    // Program bytes; an idle bus shows the inverse of the last byte
    always_comb begin
        if (prog_req.rd) begin
            prog_data = pmem[prog_req.addr];
        end else begin
            prog_data = ~prog_last;
        end
    end
    // Data bytes; upper indirect space is RAM, upper direct space is registers
    always_comb begin
        if (!data_req.rd) begin
            data_rdata = ~data_last;
        end else if (data_req.indirect || !data_req.addr[7]) begin
            data_rdata = iram[data_req.addr];
        end else if (data_req.addr == PORT_ADDR && !data_req.rmw) begin
            data_rdata = port_pins; // Pins differ from latch
        end else begin
            data_rdata = sfr[data_req.addr[6:0]];
        end
    end
    // ==================================================
    // Writes and idle-bus memory
    always @(posedge clk) begin
        if (prog_req.rd) begin
            prog_last <= prog_data;
        end
        if (data_req.rd) begin
            data_last <= data_rdata;
        end
        if (data_req.wr && (data_req.indirect || !data_req.addr[7])) begin
            iram[data_req.addr] <= data_req.wdata;
        end else if (data_req.wr) begin
            sfr[data_req.addr[6:0]] <= data_req.wdata;
        end
    end
endmodule : cace_mem_model

// file: tb_call_add_and_compare_jump_not_equal_exec.sv
// Self-checking testbench of the call, add, and and compare-jump core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_call_add_and_compare_jump_not_equal_exec;
    import cace_pkg::*;
    // ==================================================
    // Signals and instances
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic [1:0] reg_bank = 2'h0;
    logic [7:0] port_pins = 8'h00;
    cace_prog_req_s prog_req;
    cace_data_req_s data_req;
    cace_flags_s flags;
    logic [7:0] prog_data;
    logic [7:0] data_rdata;
    logic [15:0] pc;
    logic [7:0] stack_pointer_reg;
    logic [7:0] acc;
    logic retire;
    logic bad_op;
    int err_total = 0;
    int checks = 0;
    int bad_seen = 0;
    cace_core dut (.clk(clk), .resetn(resetn), .ce(ce), .reg_bank(reg_bank),
        .prog_req(prog_req), .prog_data(prog_data), .data_req(data_req),
        .data_rdata(data_rdata), .pc(pc), .stack_pointer_reg(stack_pointer_reg),
        .acc(acc), .flags(flags), .retire(retire), .bad_op(bad_op));
    cace_mem_model mem (.clk(clk), .prog_req(prog_req), .prog_data(prog_data),
        .data_req(data_req), .data_rdata(data_rdata), .port_pins(port_pins));
    // Clock and skipped-opcode watch
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (bad_op === 1'b1) bad_seen++;
    end
    // ==================================================
    // Program: address, byte count, bytes left aligned
    localparam logic [41:0] PROG [23] = '{
        {16'h0000, 2'h2, 24'h21_2300}, {16'h0123, 2'h2, 24'h71_4500},
        {16'h0345, 2'h2, 24'h24_C300}, {16'h0347, 2'h1, 24'h28_0000},
        {16'h0348, 2'h2, 24'h34_0F00}, {16'h034A, 2'h2, 24'h55_3000},
        {16'h034C, 2'h3, 24'h53_90F3}, {16'h034F, 2'h2, 24'h52_3000},
        {16'h0351, 2'h3, 24'hB4_6010}, {16'h0364, 2'h2, 24'h82_0000},
        {16'h0366, 2'h2, 24'hB0_0100}, {16'h0368, 2'h2, 24'hB0_0000},
        {16'h036A, 2'h3, 24'hB4_FF02}, {16'h036F, 2'h2, 24'h82_0100},
        {16'h0371, 2'h3, 24'hB4_FF00}, {16'h0374, 2'h3, 24'hB5_30F0},
        {16'h0377, 2'h2, 24'hE1_FE00}, {16'h07FE, 2'h2, 24'h01_0000},
        {16'h0800, 2'h1, 24'h27_0000}, {16'h0801, 2'h3, 24'hBE_6003},
        {16'h0807, 2'h3, 24'hB7_10FD}, {16'h080A, 2'h1, 24'h00_0000},
        {16'h080B, 2'h2, 24'h25_3000}};
    // ==================================================
    // Shared tasks
    task automatic close_out();
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    // Wait, bounded, for one completed instruction
    task automatic run_one();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (retire !== 1'b1 && n < 60);
        if (retire !== 1'b1) begin
            err_total++;
            close_out();
        end
    endtask : run_one
    // Run one instruction and compare the architectural state
    task automatic step(input logic [15:0] pc_e, input logic [7:0] acc_e,
            input logic [2:0] fl_e);
        run_one();
        `CHK("pc", pc_e, pc);
        `CHK("acc", acc_e, acc);
        `CHK("flags", fl_e, flags);
    endtask : step
    // ==================================================
    // Scenarios
    task automatic sc_reset();
        repeat (12) @(negedge clk);
        `CHK("pc rst", 16'h0000, pc);
        `CHK("stack rst", 8'h07, stack_pointer_reg);
        `CHK("acc rst", 8'h00, acc);
        `CHK("flags rst", 3'h0, flags);
        `CHK("fetch rst", 1'b0, prog_req.rd);
        resetn = 1'b1;
        @(posedge clk);
        #1;
        `CHK("first fetch", 17'h0_0001, {prog_req.addr, prog_req.rd});
    endtask : sc_reset
    // Jump into a page, then call that pushes the return address
    task automatic sc_jump_call();
        step(16'h0123, 8'h00, 3'h0);
        step(16'h0345, 8'h00, 3'h0);
        `CHK("stack call", 8'h09, stack_pointer_reg);
        `CHK("push lo", 8'h25, mem.iram[8'h08]);
        // The high byte lands one edge after retire
        @(posedge clk);
        #1;
        `CHK("push hi", 8'h01, mem.iram[8'h09]);
    endtask : sc_jump_call
    // Adds with a frozen clock enable first, register from bank two
    task automatic sc_add();
        @(negedge clk);
        ce = 1'b0;
        reg_bank = 2'h2;
        repeat (4) @(negedge clk);
        `CHK("pc frozen", 16'h0345, pc);
        ce = 1'b1;
        step(16'h0347, 8'hC3, 3'h0);
        step(16'h0348, 8'h6D, 3'h5);
        step(16'h034A, 8'h7D, 3'h2);
        @(negedge clk);
        reg_bank = 2'h0;
    endtask : sc_add
    // Byte ands into the accumulator, a port latch and a direct byte
    task automatic sc_and();
        step(16'h034C, 8'h58, 3'h2);
        step(16'h034F, 8'h58, 3'h2);
        // Write-back lands one edge after retire
        @(posedge clk);
        #1;
        `CHK("port latch", 8'h51, mem.sfr[7'h10]);
        step(16'h0351, 8'h58, 3'h2);
        @(posedge clk);
        #1;
        `CHK("direct and", 8'h58, mem.iram[8'h30]);
    endtask : sc_and
    // Compare-jumps and bit ands on carry
    task automatic sc_compare();
        step(16'h0364, 8'h58, 3'h6);
        step(16'h0366, 8'h58, 3'h6);
        step(16'h0368, 8'h58, 3'h6);
        step(16'h036A, 8'h58, 3'h2);
        `CHK("bit kept", 8'h01, mem.iram[8'h20]);
        step(16'h036F, 8'h58, 3'h6);
        step(16'h0371, 8'h58, 3'h2);
        step(16'h0374, 8'h58, 3'h6);
        step(16'h0377, 8'h58, 3'h2);
        `CHK("cmp operand", 8'h58, mem.iram[8'h30]);
    endtask : sc_compare
    // Jump across a 2k boundary, indirect add, register and indirect compares,
    // then one skipped opcode ahead of a direct add
    task automatic sc_page_edge();
        step(16'h07FE, 8'h58, 3'h2);
        step(16'h0800, 8'h58, 3'h2);
        step(16'h0801, 8'h68, 3'h0);
        step(16'h0807, 8'h68, 3'h4);
        step(16'h080A, 8'h68, 3'h0);
        step(16'h080D, 8'hC0, 3'h3);
        `CHK("skipped ops", 1, bad_seen);
    endtask : sc_page_edge
    // ==================================================
    // Main sequence
    initial begin
        for (int i = 0; i < 23; i++) begin
            for (int k = 0; k < int'(PROG[i][25:24]); k++) begin
                mem.pmem[PROG[i][41:26] + 16'(k)] = PROG[i][23 - 8 * k -: 8];
            end
        end
        mem.iram[8'h10] = 8'hAA;
        mem.iram[8'h01] = 8'h90;
        mem.iram[8'h06] = 8'h3C;
        mem.iram[8'h90] = 8'h10;
        mem.iram[8'h30] = 8'h5A;
        mem.iram[8'h20] = 8'h01;
        mem.sfr[7'h10] = 8'h5D;
        sc_reset();
        sc_jump_call();
        sc_add();
        sc_and();
        sc_compare();
        sc_page_edge();
        close_out();
    end
endmodule : tb_call_add_and_compare_jump_not_equal_exec
